// File: hw/capture_defines.svh
// Register map, field positions, codes and reset values of the capture channel.
`ifndef CAPTURE_DEFINES_SVH
`define CAPTURE_DEFINES_SVH

// ************************************************************
// Register byte offsets on the bus
// ************************************************************
`define CAP_ADR_CONTROL_ONE  4'h0
`define CAP_ADR_CONTROL_TWO  4'h4
`define CAP_ADR_BUFFER       4'h8
`define CAP_ADR_COUNTER      4'hc

// ************************************************************
// Control one field positions
// ************************************************************
`define CAP_C1_HALT_IDLE     13
`define CAP_C1_TSEL_LSB      10
`define CAP_C1_ICI_LSB       5
`define CAP_C1_OVERFLOW      4
`define CAP_C1_NOT_EMPTY     3
`define CAP_C1_MODE_LSB      0

// ************************************************************
// Control two field positions
// ************************************************************
`define CAP_C2_CASCADE       8
`define CAP_C2_TRIG_SELECT   7
`define CAP_C2_TRIG_RUNNING  6
`define CAP_C2_SYNC_LSB      0

// ************************************************************
// Capture mode codes
// ************************************************************
`define CAP_MODE_OFF         3'h0
`define CAP_MODE_BOTH_EDGES  3'h1
`define CAP_MODE_FALLING     3'h2
`define CAP_MODE_RISING      3'h3
`define CAP_MODE_EVERY_4TH   3'h4
`define CAP_MODE_EVERY_16TH  3'h5
`define CAP_MODE_UNUSED      3'h6
`define CAP_MODE_WAKE_IRQ    3'h7

// ************************************************************
// Time base select codes
// ************************************************************
`define CAP_TSEL_TIMER3      3'h0
`define CAP_TSEL_TIMER2      3'h1
`define CAP_TSEL_TIMER4      3'h2
`define CAP_TSEL_TIMER5      3'h3
`define CAP_TSEL_TIMER1      3'h4
`define CAP_TSEL_SYSCLK      3'h7

// ************************************************************
// Sync source codes, prescale counts, reset values
// ************************************************************
`define CAP_SYNC_NONE        5'h00
`define CAP_PRESCALE_4_LAST  4'h3
`define CAP_PRESCALE_16_LAST 4'hf
`define CAP_COUNT_ALL_ONES   16'hffff
`define CAP_RESET_VALUE      16'h0000
`define CAP_FIFO_DEPTH       4

`endif

// File: hw/capture_pkg.sv
// Types shared by the capture channel files.
package capture_pkg;
	typedef logic [15:0] count_t;
	typedef logic [2:0]  mode_code_t;
	typedef logic [2:0]  tsel_code_t;
	typedef logic [4:0]  source_code_t;
	typedef logic [1:0]  fifo_ptr_t;
endpackage : capture_pkg

// File: hw/capture_edge_prescaler.sv
// Edge detector and rising-edge prescaler for the capture pin.
`timescale 1ns/1ps
`include "capture_defines.svh"

module capture_edge_prescaler
	import capture_pkg::*;
(
	// Clock and reset.
	input  wire logic        mclk,
	input  wire logic        nrst,
	// Synchronised pin level and configuration.
	input  wire logic        pinLevel,
	input  wire logic        enable,
	input  wire mode_code_t  mode,
	// Edge results.
	output logic             capturePulse,
	output logic             risePulse
);

	logic       level_q;
	logic [3:0] rises_q;
	logic       rise;
	logic       fall;
	logic [3:0] lastCount;

	assign rise      = pinLevel & ~level_q;
	assign fall      = ~pinLevel & level_q;
	assign lastCount = (mode == `CAP_MODE_EVERY_16TH) ? `CAP_PRESCALE_16_LAST : `CAP_PRESCALE_4_LAST;

	// Previous level for edge detection.
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			level_q <= 1'b0;
		end else begin
			level_q <= pinLevel;
		end
	end

	// Rising edge count; cleared while disabled so the prescale restarts clean.
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			rises_q <= 4'h0;
		end else if (!enable) begin
			rises_q <= 4'h0;
		end else if (rise) begin
			rises_q <= (rises_q == lastCount) ? 4'h0 : rises_q + 4'h1;
		end
	end

	// Capture decision per mode.
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			capturePulse <= 1'b0;
			risePulse    <= 1'b0;
		end else begin
			risePulse <= rise;
			case (mode)
				`CAP_MODE_BOTH_EDGES: capturePulse <= enable & (rise | fall);
				`CAP_MODE_FALLING:    capturePulse <= enable & fall;
				`CAP_MODE_RISING:     capturePulse <= enable & rise;
				`CAP_MODE_EVERY_4TH,
				`CAP_MODE_EVERY_16TH: capturePulse <= enable & rise & (rises_q == lastCount);
				default:              capturePulse <= 1'b0;
			endcase
		end
	end

endmodule : capture_edge_prescaler

// File: hw/capture_fifo.sv
// Four-entry first-in first-out store of captured counts.
`timescale 1ns/1ps
`include "capture_defines.svh"

module capture_fifo
	import capture_pkg::*;
(
	// Clock and reset.
	input  wire logic   mclk,
	input  wire logic   nrst,
	// Control.
	input  wire logic   flush,
	input  wire logic   push,
	input  wire count_t pushData,
	input  wire logic   pop,
	// State.
	output count_t      headData,
	output logic        notEmpty,
	output logic        full
);

	count_t    store [`CAP_FIFO_DEPTH];
	fifo_ptr_t wrPtr_q;
	fifo_ptr_t rdPtr_q;
	logic [2:0] fill_q;
	logic       doPush;
	logic       doPop;

	assign doPush   = push & (fill_q != 3'(`CAP_FIFO_DEPTH));
	assign doPop    = pop & (fill_q != 3'h0);
	assign headData = store[rdPtr_q];
	assign notEmpty = (fill_q != 3'h0);
	assign full     = (fill_q == 3'(`CAP_FIFO_DEPTH));

	// Storage array, written at the write pointer.
	always_ff @(posedge mclk) begin
		if (doPush) begin
			store[wrPtr_q] <= pushData;
		end
	end

	// Pointers and fill level; push and pop in one cycle keep the level unless the store is full or empty.
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			wrPtr_q <= 2'h0;
			rdPtr_q <= 2'h0;
			fill_q  <= 3'h0;
		end else if (flush) begin
			wrPtr_q <= 2'h0;
			rdPtr_q <= 2'h0;
			fill_q  <= 3'h0;
		end else begin
			if (doPush) begin
				wrPtr_q <= wrPtr_q + 2'h1;
			end
			if (doPop) begin
				rdPtr_q <= rdPtr_q + 2'h1;
			end
			fill_q <= fill_q + {2'h0, doPush} - {2'h0, doPop};
		end
	end

endmodule : capture_fifo

// File: hw/input_capture_dedicated_timer.sv
// One input capture channel with its own 16-bit time base and a Wishbone register port.
`timescale 1ns/1ps
`include "capture_defines.svh"

module input_capture_dedicated_timer
	import capture_pkg::*;
#(
	parameter logic UPPER_HALF = 1'b0
) (
	// Clock and reset.
	input  wire logic        mclk,
	input  wire logic        nrst,
	// Wishbone slave.
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [3:0]  wb_adr_i,
	input  wire logic [31:0] wb_dat_i,
	input  wire logic [3:0]  wb_sel_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	// Capture pin, asynchronous.
	input  wire logic        captureInput,
	// CPU power state.
	input  wire logic        cpuIdle,
	input  wire logic        cpuSleep,
	// Timer tick enables, bit 0 is timer 1 up to bit 4 timer 5.
	input  wire logic [4:0]  timerTicks,
	// Sync and trigger event pulses indexed by source code.
	input  wire logic [31:0] syncEvents,
	// Cascade partner, the lower channel of the pair.
	input  wire logic        partnerCarry,
	input  wire logic        partnerCapture,
	// Channel events.
	output logic             captureIrq,
	output logic             captureStrobe,
	output logic             carryOut
);

	// ************************************************************
	// Decoding helpers
	// ************************************************************

	// Pick the counter tick for a time base code; reserved codes never tick.
	function automatic logic timeBaseTick(input tsel_code_t sel, input logic [4:0] ticks);
		case (sel)
			`CAP_TSEL_SYSCLK: timeBaseTick = 1'b1;
			`CAP_TSEL_TIMER1: timeBaseTick = ticks[0];
			`CAP_TSEL_TIMER5: timeBaseTick = ticks[4];
			`CAP_TSEL_TIMER4: timeBaseTick = ticks[3];
			`CAP_TSEL_TIMER2: timeBaseTick = ticks[1];
			`CAP_TSEL_TIMER3: timeBaseTick = ticks[2];
			default:          timeBaseTick = 1'b0;
		endcase
	endfunction : timeBaseTick

	// True for a source code that names a real event source.
	function automatic logic sourceImplemented(input source_code_t code);
		sourceImplemented = (code >= 5'h01 && code <= 5'h06) || (code >= 5'h0b && code <= 5'h0f)
			|| (code >= 5'h10 && code <= 5'h15) || (code >= 5'h18 && code <= 5'h1c);
	endfunction : sourceImplemented

	// True for a mode code that runs the counter and captures.
	function automatic logic modeCaptures(input mode_code_t code);
		modeCaptures = (code != `CAP_MODE_OFF) && (code != `CAP_MODE_UNUSED)
			&& (code != `CAP_MODE_WAKE_IRQ);
	endfunction : modeCaptures

	// ************************************************************
	// Register state
	// ************************************************************
	logic         haltInIdle_q;
	tsel_code_t   timeBaseSelect_q;
	logic [1:0]   capturesPerInterrupt_q;
	logic         captureOverflowFlag_q;
	mode_code_t   captureMode_q;
	logic         cascadeEnable_q;
	logic         syncOrTriggerSelect_q;
	logic         triggerRunning_q;
	source_code_t syncSourceSelect_q;
	count_t       captureCounter_q;
	logic [1:0]   irqCount_q;
	logic         pinMeta_q;
	logic         pinSync_q;

	// ************************************************************
	// Bus decode
	// ************************************************************
	logic   busTake;
	logic   wrOne;
	logic   wrTwo;
	logic   rdBuffer;
	count_t bufferHead;
	logic   bufferNotEmpty;
	logic   bufferFull;

	// A request is taken once; ack follows in the next cycle and drops after one.
	assign busTake  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign wrOne    = busTake & wb_we_i & (wb_adr_i == `CAP_ADR_CONTROL_ONE);
	assign wrTwo    = busTake & wb_we_i & (wb_adr_i == `CAP_ADR_CONTROL_TWO);
	assign rdBuffer = busTake & ~wb_we_i & (wb_adr_i == `CAP_ADR_BUFFER);

	// ************************************************************
	// Channel control terms
	// ************************************************************
	logic frozen;
	logic active;
	logic run;
	logic heldClear;
	logic sourceEvent;
	logic cascadeUpper;
	logic tick;
	logic syncReset;
	logic edgeCapture;
	logic pinRise;
	logic captureEvent;
	logic counterWraps;

	assign frozen       = haltInIdle_q & cpuIdle;
	assign active       = modeCaptures(captureMode_q);
	assign run          = active & ~frozen;
	assign heldClear    = syncOrTriggerSelect_q & ~triggerRunning_q;
	assign sourceEvent  = sourceImplemented(syncSourceSelect_q) & syncEvents[syncSourceSelect_q];
	assign cascadeUpper = cascadeEnable_q & UPPER_HALF;
	assign tick         = cascadeUpper ? partnerCarry : timeBaseTick(timeBaseSelect_q, timerTicks);
	assign syncReset    = ~syncOrTriggerSelect_q & sourceEvent;
	assign captureEvent = run & ~heldClear & (cascadeUpper ? partnerCapture : edgeCapture);
	assign counterWraps = run & ~heldClear & ~syncReset & tick & (captureCounter_q == `CAP_COUNT_ALL_ONES);

	// ************************************************************
	// Pin synchroniser
	// ************************************************************

	// Two flops before any logic reads the pin.
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			pinMeta_q <= 1'b0;
			pinSync_q <= 1'b0;
		end else begin
			pinMeta_q <= captureInput;
			pinSync_q <= pinMeta_q;
		end
	end

	// ************************************************************
	// Edge detection and buffer
	// ************************************************************
	capture_edge_prescaler edges (
		.mclk         (mclk),
		.nrst         (nrst),
		.pinLevel     (pinSync_q),
		.enable       (run & ~heldClear),
		.mode         (captureMode_q),
		.capturePulse (edgeCapture),
		.risePulse    (pinRise)
	);

	capture_fifo buffer (
		.mclk     (mclk),
		.nrst     (nrst),
		.flush    (1'b0),
		.push     (captureEvent),
		.pushData (captureCounter_q),
		.pop      (rdBuffer),
		.headData (bufferHead),
		.notEmpty (bufferNotEmpty),
		.full     (bufferFull)
	);

	// ************************************************************
	// Control register one
	// ************************************************************

	// Software fields, with byte lanes honoured.
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			haltInIdle_q           <= 1'b0;
			timeBaseSelect_q       <= 3'h0;
			capturesPerInterrupt_q <= 2'h0;
			captureMode_q          <= `CAP_MODE_OFF;
		end else if (wrOne) begin
			if (wb_sel_i[1]) begin
				haltInIdle_q     <= wb_dat_i[`CAP_C1_HALT_IDLE];
				timeBaseSelect_q <= wb_dat_i[`CAP_C1_TSEL_LSB +: 3];
			end
			if (wb_sel_i[0]) begin
				capturesPerInterrupt_q <= wb_dat_i[`CAP_C1_ICI_LSB +: 2];
				captureMode_q          <= wb_dat_i[`CAP_C1_MODE_LSB +: 3];
			end
		end
	end

	// Overflow is hardware-owned: a lost capture sets it, switching off clears it.
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			captureOverflowFlag_q <= 1'b0;
		end else if (captureEvent & bufferFull) begin
			captureOverflowFlag_q <= 1'b1;
		end else if (captureMode_q == `CAP_MODE_OFF) begin
			captureOverflowFlag_q <= 1'b0;
		end
	end

	// ************************************************************
	// Control register two
	// ************************************************************

	// Cascade, trigger select and source select.
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			cascadeEnable_q       <= 1'b0;
			syncOrTriggerSelect_q <= 1'b0;
			syncSourceSelect_q    <= `CAP_SYNC_NONE;
		end else if (wrTwo) begin
			if (wb_sel_i[1]) begin
				cascadeEnable_q <= wb_dat_i[`CAP_C2_CASCADE];
			end
			if (wb_sel_i[0]) begin
				syncOrTriggerSelect_q <= wb_dat_i[`CAP_C2_TRIG_SELECT];
				syncSourceSelect_q    <= wb_dat_i[`CAP_C2_SYNC_LSB +: 5];
			end
		end
	end

	// A trigger from the source sets the bit even in the cycle software clears it.
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			triggerRunning_q <= 1'b0;
		end else if (syncOrTriggerSelect_q & sourceEvent) begin
			triggerRunning_q <= 1'b1;
		end else if (wrTwo & wb_sel_i[0]) begin
			triggerRunning_q <= wb_dat_i[`CAP_C2_TRIG_RUNNING];
		end
	end

	// ************************************************************
	// Time base counter
	// ************************************************************

	// Off or untriggered holds zero; halted in idle holds its value; else a sync event restarts or a tick counts.
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			captureCounter_q <= `CAP_RESET_VALUE;
		end else if (!active || heldClear) begin
			captureCounter_q <= `CAP_RESET_VALUE;
		end else if (run && syncReset) begin
			captureCounter_q <= `CAP_RESET_VALUE;
		end else if (run && tick) begin
			captureCounter_q <= captureCounter_q + 16'h0001;
		end
	end

	// ************************************************************
	// Interrupt pacing and channel event outputs
	// ************************************************************

	// Count captures; wake mode fires on a rising edge only when the CPU sleeps or idles.
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			irqCount_q <= 2'h0;
			captureIrq <= 1'b0;
		end else if (captureMode_q == `CAP_MODE_OFF) begin
			irqCount_q <= 2'h0;
			captureIrq <= 1'b0;
		end else if (captureMode_q == `CAP_MODE_WAKE_IRQ) begin
			irqCount_q <= 2'h0;
			captureIrq <= pinRise & (cpuSleep | cpuIdle);
		end else if (captureEvent && captureMode_q == `CAP_MODE_BOTH_EDGES) begin
			irqCount_q <= 2'h0;
			captureIrq <= 1'b1;
		end else if (captureEvent) begin
			irqCount_q <= (irqCount_q == capturesPerInterrupt_q) ? 2'h0 : irqCount_q + 2'h1;
			captureIrq <= (irqCount_q == capturesPerInterrupt_q);
		end else begin
			captureIrq <= 1'b0;
		end
	end

	// Pulses the partner and other channels may use as sync sources.
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			captureStrobe <= 1'b0;
			carryOut      <= 1'b0;
		end else begin
			captureStrobe <= captureEvent;
			carryOut      <= counterWraps;
		end
	end

	// ************************************************************
	// Bus answer
	// ************************************************************

	// Registered read data; unmapped addresses read zero and ignore writes.
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= busTake;
			if (busTake && !wb_we_i) begin
				wb_dat_o <= 32'h0000_0000;
				case (wb_adr_i)
					`CAP_ADR_CONTROL_ONE: begin
						wb_dat_o[`CAP_C1_HALT_IDLE]       <= haltInIdle_q;
						wb_dat_o[`CAP_C1_TSEL_LSB +: 3]   <= timeBaseSelect_q;
						wb_dat_o[`CAP_C1_ICI_LSB +: 2]    <= capturesPerInterrupt_q;
						wb_dat_o[`CAP_C1_OVERFLOW]        <= captureOverflowFlag_q;
						wb_dat_o[`CAP_C1_NOT_EMPTY]       <= bufferNotEmpty;
						wb_dat_o[`CAP_C1_MODE_LSB +: 3]   <= captureMode_q;
					end
					`CAP_ADR_CONTROL_TWO: begin
						wb_dat_o[`CAP_C2_CASCADE]         <= cascadeEnable_q;
						wb_dat_o[`CAP_C2_TRIG_SELECT]     <= syncOrTriggerSelect_q;
						wb_dat_o[`CAP_C2_TRIG_RUNNING]    <= triggerRunning_q;
						wb_dat_o[`CAP_C2_SYNC_LSB +: 5]   <= syncSourceSelect_q;
					end
					`CAP_ADR_BUFFER: begin
						wb_dat_o[15:0] <= bufferNotEmpty ? bufferHead : 16'h0000;
					end
					`CAP_ADR_COUNTER: begin
						wb_dat_o[15:0] <= captureCounter_q;
					end
					default: begin
						wb_dat_o <= 32'h0000_0000;
					end
				endcase
			end
		end
	end

endmodule : input_capture_dedicated_timer

// File: dv/capture_pin_model.sv
// Behavioural source of the capture pin: a square wave with a set half period.
`timescale 1ns/1ps
module capture_pin_model (
	// Clock.
	input  wire logic       mclk,
	// Wave control.
	input  wire logic       run,
	input  wire logic [7:0] halfPeriod,
	// Pin level and rising edge tally.
	output logic            captureInput,
	output int              rises
);
	int cnt;
	initial begin
		captureInput = 1'h0;
		rises = 0;
		cnt = 0;
	end
	// The level moves only while running, so a stopped wave leaves a quiet pin.
	always @(posedge mclk) begin
		cnt <= run ? cnt + 1 : 0;
		if (run && cnt + 1 >= halfPeriod) begin
			cnt <= 0;
			captureInput <= ~captureInput;
			rises <= rises + !captureInput;
		end
	end
endmodule : capture_pin_model

// File: dv/input_capture_dedicated_timer_props.sv
// Port assertions of the capture channel.
`timescale 1ns/1ps
module input_capture_dedicated_timer_props (
	// Clock and reset.
	input wire logic        mclk,
	input wire logic        nrst,
	// Register bus.
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic [3:0]  wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [3:0]  wb_sel_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic        wb_ack_o,
	// Power state and events.
	input wire logic        cpuIdle,
	input wire logic        cpuSleep,
	input wire logic        captureIrq,
	input wire logic        captureStrobe,
	input wire logic        carryOut
);
	logic [2:0] modeQ, stabQ, quietQ, wakeQ;
	logic       haltQ, wrOne;
	assign wrOne = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o & (wb_adr_i == 4'h0);
	// Saturating count, so a window skips the few cycles of the capture pipeline.
	function automatic logic [2:0] bump(input logic c, input logic [2:0] v);
		return c ? v + {2'h0, v != 3'h7} : 3'h0;
	endfunction : bump
	// Shadow of mode and halt, taken at the edge where the slave takes the write.
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			modeQ <= 3'h0;
			haltQ <= 1'h0;
		end else if (wrOne) begin
			if (wb_sel_i[0])
				modeQ <= wb_dat_i[2:0];
			if (wb_sel_i[1])
				haltQ <= wb_dat_i[13];
		end
	end
	// Cycles since a control one write, in a quiet setting, and in mode 111 while awake.
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			stabQ <= 3'h0;
			quietQ <= 3'h0;
			wakeQ <= 3'h0;
		end else begin
			stabQ <= bump(!wrOne, stabQ);
			quietQ <= bump(!wrOne && (modeQ inside {3'h0, 3'h6, 3'h7} || (haltQ && cpuIdle)), quietQ);
			wakeQ <= bump(!wrOne && modeQ == 3'h7 && !cpuIdle && !cpuSleep, wakeQ);
		end
	end
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!nrst);
	ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held too long");
	ack_latency_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("no answer");
	ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i)) else $error("ack without request");
	read_zeros_a: assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0 &&
		($past(wb_adr_i) != 4'h4 || $past(wb_we_i) || wb_dat_o[15:9] == 7'h0)) else $error("unused bits set");
	carry_single_a: assert property (carryOut |=> !carryOut [*8]) else $error("carry repeated");
	quiet_strobe_a: assert property (quietQ == 3'h7 |-> !captureStrobe) else $error("capture while off");
	wake_irq_a: assert property (wakeQ == 3'h7 |-> !captureIrq) else $error("irq while awake");
	both_edge_irq_a: assert property (stabQ == 3'h7 && modeQ == 3'h1 && captureStrobe |-> captureIrq)
		else $error("edge irq missing");
endmodule : input_capture_dedicated_timer_props

bind input_capture_dedicated_timer input_capture_dedicated_timer_props input_capture_dedicated_timer_props_i (
	.mclk, .nrst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_dat_o, .wb_ack_o,
	.cpuIdle, .cpuSleep, .captureIrq, .captureStrobe, .carryOut);

// File: dv/input_capture_dedicated_timer_tb_top.sv
// Self-checking bench of the capture channel with a pin wave partner.
`timescale 1ns/1ps
module input_capture_dedicated_timer_tb_top
	import capture_pkg::*;
;
	logic        mclk, nrst, cyc, stb, we, ack, run, cpuIdle, cpuSleep, captureIrq, captureStrobe, captureInput;
	logic        carryOut;
	logic [3:0]  adr;
	logic [4:0]  ticks;
	logic [7:0]  half;
	logic [1:0]  captures_per_interrupt;
	logic [2:0]  m;
	logic [2:0]  tsels [6] = '{3'h7, 3'h4, 3'h3, 3'h2, 3'h1, 3'h0};
	logic [31:0] wdat, dout, rdq, syncEv, seed, cfg;
	count_t      caps [4];
	int          failures, compares, rises, s0, i0;
	int          strobeCnt = 0, irqCnt = 0, cycles = 0, carryCnt = 0;
	input_capture_dedicated_timer input_capture_dedicated_timer_i (
		.mclk, .nrst, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat),
		.wb_sel_i(4'h3), .wb_dat_o(dout), .wb_ack_o(ack), .captureInput, .cpuIdle, .cpuSleep,
		.timerTicks(ticks), .syncEvents(syncEv), .partnerCarry(1'h0), .partnerCapture(1'h0),
		.captureIrq, .captureStrobe, .carryOut);
	capture_pin_model capture_pin_model_i (.mclk, .run, .halfPeriod(half), .captureInput, .rises);
	// Clock of 50 ns.
	initial begin
		mclk = 1'h0;
		forever #25 mclk = ~mclk;
	end
	// Event tallies, one timer tick every fifth cycle per source, and the hang guard.
	always @(posedge mclk) begin
		strobeCnt <= strobeCnt + captureStrobe;
		irqCnt <= irqCnt + captureIrq;
		carryCnt <= carryCnt + carryOut;
		ticks <= 5'h1 << (cycles % 5);
		cycles <= cycles + 1;
		// A full counter wrap alone takes 65536 cycles, so the ceiling leaves room for it.
		if (cycles == 90000) begin
			failures++;
			conclude();
		end
	end
	task automatic conclude();
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : conclude
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			failures++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	// One classic cycle; read data is taken at the edge that sees ack.
	task automatic wb(input logic [3:0] a, input logic w, input logic [31:0] d);
		{cyc, stb, we, adr, wdat} <= {2'h3, w, a, d};
		@(posedge mclk);
		while (ack !== 1'h1)
			@(posedge mclk);
		rdq = dout;
		{cyc, stb} <= 2'h0;
		@(posedge mclk);
	endtask : wb
	task automatic drain();
		wb(0, 0, 0);
		while (rdq[3] === 1'h1) begin
			wb(8, 0, 0);
			wb(0, 0, 0);
		end
	endtask : drain
	task automatic idle(input int n);
		repeat (n) @(posedge mclk);
	endtask : idle
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	// Timer sources tick once in five cycles, so a gap in cycles shrinks fivefold.
	function automatic int gap(input logic [2:0] md, input logic [7:0] h, input logic [2:0] ts);
		int g;
		g = (md == 3'h1) ? h : (md == 3'h4) ? 8 * h : (md == 3'h5) ? 32 * h : 2 * h;
		return (ts == 3'h7) ? g : g / 5;
	endfunction : gap
	initial begin
		{nrst, cyc, stb, we, adr, wdat, run, cpuIdle, cpuSleep, syncEv} = '0;
		{failures, compares} = '0;
		seed = 32'h34;
		half = 8'ha;
		idle(4);
		nrst <= 1'h1;
		idle(1);
		for (int a = 0; a < 12; a += 2) begin
			wb(4'(a), 0, 0);
			chk("reset read", 0, rdq);
		end
		wb(0, 1, 32'hfffffff8);
		wb(0, 0, 0);
		chk("control one", 32'h3c60, rdq);
		wb(4, 1, 32'hffffffff);
		wb(4, 0, 0);
		chk("control two", 32'h1df, rdq);
		for (int i = 0; i < 6; i++) begin
			m = 3'(i % 5 + 1);
			captures_per_interrupt = 2'(rnd());
			half <= 8'(5 * (2 + rnd() % 3));
			cfg = {19'h0, tsels[i], 3'h0, captures_per_interrupt, 2'h0, m};
			wb(4, 1, 0);
			wb(0, 1, cfg);
			{s0, i0} = {strobeCnt, irqCnt};
			run <= 1'h1;
			while (strobeCnt < s0 + 4)
				@(posedge mclk);
			run <= 1'h0;
			idle(10);
			wb(0, 0, 0);
			chk("status full", cfg | 32'h8, rdq);
			for (int k = 0; k < 4; k++) begin
				wb(8, 0, 0);
				caps[k] = rdq[15:0];
			end
			for (int k = 1; k < 4; k++)
				chk("capture gap", gap(m, half, tsels[i]), {16'h0, count_t'(caps[k] - caps[k - 1])});
			chk("irq count", (m == 3'h1) ? 4 : 4 / (captures_per_interrupt + 1), irqCnt - i0);
			wb(0, 1, cfg & ~32'h7);
			wb(0, 0, 0);
			chk("status empty", cfg & ~32'h7, rdq);
		end
		wb(0, 1, 32'h1c03);
		wb(4, 1, 32'h80);
		wb(12, 0, 0);
		chk("held counter", 0, rdq);
		wb(4, 1, 32'hc0);
		wb(12, 0, 0);
		s0 = rdq;
		wb(12, 0, 0);
		chk("counter step", 3, rdq - s0);
		wb(4, 1, 32'h0b);
		idle(40);
		syncEv <= 32'h800;
		idle(1);
		syncEv <= 32'h0;
		wb(12, 0, 0);
		chk("sync restart", 1, rdq < 32'h10);
		wb(4, 1, 0);
		s0 = rises;
		run <= 1'h1;
		while (rises < s0 + 5)
			@(posedge mclk);
		idle(12);
		run <= 1'h0;
		idle(12);
		wb(0, 0, 0);
		chk("overflow", 32'h1c1b, rdq);
		drain();
		wb(0, 1, 32'h1c00);
		wb(0, 0, 0);
		chk("overflow cleared", 32'h1c00, rdq);
		wb(0, 1, 32'h3c03);
		cpuIdle <= 1'h1;
		s0 = strobeCnt;
		run <= 1'h1;
		idle(200);
		chk("halted in idle", s0, strobeCnt);
		wb(0, 1, 32'h1c03);
		idle(200);
		chk("running in idle", 1, strobeCnt > s0);
		drain();
		wb(0, 1, 32'h1c06);
		idle(8);
		s0 = strobeCnt;
		idle(200);
		chk("unused mode", s0, strobeCnt);
		cpuIdle <= 1'h0;
		cpuSleep <= 1'h1;
		wb(0, 1, 32'h1c07);
		idle(8);
		{s0, i0} = {strobeCnt, irqCnt};
		idle(200);
		chk("sleep irq", 1, irqCnt > i0);
		chk("sleep capture", s0, strobeCnt);
		cpuSleep <= 1'h0;
		idle(8);
		i0 = irqCnt;
		idle(200);
		chk("awake irq", i0, irqCnt);
		run <= 1'h0;
		// Free run on the system clock from zero until the counter wraps once.
		wb(0, 1, 32'h1c03);
		s0 = carryCnt;
		while (carryCnt == s0)
			@(posedge mclk);
		wb(12, 0, 0);
		chk("wrap restart", 1, rdq < 32'h10);
		chk("carry count", s0 + 1, carryCnt);
		conclude();
	end
endmodule : input_capture_dedicated_timer_tb_top
